//--- verilog/tws_slave.v
// Two-wire serial memory slave: bus protocol, write buffer and array
//
// Notes on behaviour
// - START is SDA falling while SCL high
// - STOP is SDA rising while SCL high
// - Receiver pulls SDA low on ninth clock
// - Acknowledge the address byte after START
// - Acknowledge every byte of a write while the write buffer has room
// - Send eight bits, release, sample master acknowledge
// - Missing master acknowledge: idle until STOP or repeated START
// - STOP after a write starts programming
// - Ignore everything while programming runs
// - Page write lands in one four-byte page; the buffer takes up to 32 bytes
// - Step only low page bits per byte
// - Excess bytes wrap and overwrite page
// - Commit buffered bytes to the array one per clock while programming
// - No acknowledge while busy, acknowledge after
// - Byte read: address with read bit, data
// - Next byte for each master acknowledge
// - Read counter steps all address bits
`include "tws_defs.vh"
`default_nettype none

module tws_slave #(
   parameter [31:0] WR_CYCLES = `TWS_T_WR_NS / `TWS_CLK_PERIOD_NS,
   parameter FIFO_DEPTH = `TWS_FIFO_DEPTH,
   parameter FIFO_AW = `TWS_FIFO_AW
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Serial clock from the bus master
   input wire scl_i,
   // Open-drain serial data
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe,
   // Status
   output wire wr_busy
);

   localparam AW = `TWS_ADDR_W;
   localparam DW = `TWS_DATA_W;
   localparam PB = `TWS_PAGE_BITS;
   localparam EW = AW + DW;
   localparam [2:0] ST_IDLE = 3'b000;
   localparam [2:0] ST_RX = 3'b001;
   localparam [2:0] ST_ACK = 3'b010;
   localparam [2:0] ST_TX = 3'b011;
   localparam [2:0] ST_MACK = 3'b100;
   localparam [2:0] ST_WAIT = 3'b101;

   // Synchronised bus lines and their previous values
   wire [1:0] bus_s;
   wire scl_s;
   wire sda_s;
   reg scl_d_r;
   reg sda_d_r;

   // Bus conditions and clock edges
   wire start_det;
   wire stop_det;
   wire scl_rise;
   wire scl_fall;

   // Protocol state
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [1:0] kind_r;
   reg [3:0] cnt_r;
   reg [DW-1:0] rx_sh_r;
   reg [DW-1:0] tx_sh_r;
   reg [AW-1:0] ptr_r;
   reg rd_mode_r;
   reg wr_pend_r;
   reg sda_oe_r;
   reg sda_o_r;

   // Array and programming cycle
   reg [DW-1:0] mem_r [0:`TWS_MEM_WORDS-1];
   reg busy_r;
   reg [31:0] wr_tmr_r;

   // Write buffer
   reg push_r;
   reg [EW-1:0] push_data_r;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [EW-1:0] fifo_out_data;
   wire [AW-1:0] cur_byte_addr;
   wire [AW-1:0] page_next;
   wire [AW-1:0] seq_next;

   tws_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .async_i({scl_i, sda_i}),
      .sync_o(bus_s)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   always @(posedge clk) begin
      if (srst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // SDA changes only count while SCL stays high over both samples
   assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;

   // Write pointer steps inside the page, read pointer across the array
   assign cur_byte_addr = ptr_r;
   assign page_next = {ptr_r[AW-1:PB], ptr_r[PB-1:0] + {{(PB-1){1'b0}}, 1'b1}};
   assign seq_next = ptr_r + {{(AW-1){1'b0}}, 1'b1};

   // Next state of the bus machine
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            state_nxt = ST_IDLE;
         end
         ST_RX: begin
            if (scl_fall && cnt_r == `TWS_BYTE_BITS) begin
               if (kind_r == `TWS_KIND_DATA && !fifo_in_ready) begin
                  state_nxt = ST_WAIT;
               end else begin
                  state_nxt = ST_ACK;
               end
            end
         end
         ST_ACK: begin
            if (scl_fall) begin
               state_nxt = rd_mode_r ? ST_TX : ST_RX;
            end
         end
         ST_TX: begin
            if (scl_fall && cnt_r == `TWS_BYTE_BITS) begin
               state_nxt = ST_MACK;
            end
         end
         ST_MACK: begin
            if (scl_rise) begin
               state_nxt = sda_s ? ST_WAIT : ST_ACK;
            end
         end
         ST_WAIT: begin
            state_nxt = ST_WAIT;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Bus machine, shift registers and pointer
   always @(posedge clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         kind_r <= `TWS_KIND_CTRL;
         cnt_r <= `TWS_CNT_ZERO;
         rx_sh_r <= {DW{1'b0}};
         tx_sh_r <= {DW{1'b0}};
         ptr_r <= {AW{1'b0}};
         rd_mode_r <= 1'b0;
         wr_pend_r <= 1'b0;
         sda_oe_r <= 1'b0;
         sda_o_r <= 1'b0;
         push_r <= 1'b0;
         push_data_r <= {EW{1'b0}};
      end else begin
         push_r <= 1'b0;
         sda_o_r <= 1'b0;
         if (busy_r) begin
            // Interface is deaf while programming; a poll gets no ACK
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            wr_pend_r <= 1'b0;
         end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            rd_mode_r <= 1'b0;
         end else if (start_det) begin
            // Repeated START also restarts the address phase
            state_r <= ST_RX;
            kind_r <= `TWS_KIND_CTRL;
            cnt_r <= `TWS_CNT_ZERO;
            rd_mode_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else begin
            state_r <= state_nxt;
            case (state_r)
               ST_RX: begin
                  if (scl_rise && cnt_r != `TWS_BYTE_BITS) begin
                     rx_sh_r <= {rx_sh_r[DW-2:0], sda_s};
                     cnt_r <= cnt_r + `TWS_CNT_ONE;
                  end else if (scl_fall && cnt_r == `TWS_BYTE_BITS) begin
                     cnt_r <= `TWS_CNT_ZERO;
                     case (kind_r)
                        `TWS_KIND_CTRL: begin
                           // Upper seven bits address the array directly
                           sda_oe_r <= 1'b1;
                           rd_mode_r <= (rx_sh_r[`TWS_RW_BIT] == `TWS_DIR_READ);
                           ptr_r <= rx_sh_r[DW-1:1];
                           tx_sh_r <= mem_r[rx_sh_r[DW-1:1]];
                           kind_r <= `TWS_KIND_WADDR;
                        end
                        `TWS_KIND_WADDR: begin
                           sda_oe_r <= 1'b1;
                           ptr_r <= rx_sh_r[AW-1:0];
                           kind_r <= `TWS_KIND_DATA;
                        end
                        default: begin
                           // Buffer overflow beyond the FIFO depth is refused
                           if (fifo_in_ready) begin
                              sda_oe_r <= 1'b1;
                              push_r <= 1'b1;
                              push_data_r <= {cur_byte_addr, rx_sh_r};
                              ptr_r <= page_next;
                              wr_pend_r <= 1'b1;
                           end
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rd_mode_r) begin
                        // Open drain: drive low for a zero bit only
                        sda_oe_r <= !tx_sh_r[DW-1];
                        tx_sh_r <= {tx_sh_r[DW-2:0], 1'b1};
                        cnt_r <= `TWS_CNT_ONE;
                     end else begin
                        sda_oe_r <= 1'b0;
                        cnt_r <= `TWS_CNT_ZERO;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (cnt_r == `TWS_BYTE_BITS) begin
                        sda_oe_r <= 1'b0;
                        cnt_r <= `TWS_CNT_ZERO;
                     end else begin
                        sda_oe_r <= !tx_sh_r[DW-1];
                        tx_sh_r <= {tx_sh_r[DW-2:0], 1'b1};
                        cnt_r <= cnt_r + `TWS_CNT_ONE;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise && !sda_s) begin
                     ptr_r <= seq_next;
                     tx_sh_r <= mem_r[seq_next];
                  end
               end
               default: begin
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Write buffer between the bus side and the array
   tws_fifo #(
      .WIDTH(EW),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(push_r),
      .in_ready(fifo_in_ready),
      .in_data(push_data_r),
      .out_valid(fifo_out_valid),
      .out_ready(busy_r),
      .out_data(fifo_out_data)
   );

   // Array drains the buffer only while programming, so a page fills first
   always @(posedge clk) begin
      if (busy_r && fifo_out_valid) begin
         mem_r[fifo_out_data[EW-1:DW]] <= fifo_out_data[DW-1:0];
      end
   end

   // Self-timed programming cycle
   always @(posedge clk) begin
      if (srst) begin
         busy_r <= 1'b0;
         wr_tmr_r <= 32'h00000000;
      end else if (!busy_r) begin
         if (stop_det && wr_pend_r) begin
            busy_r <= 1'b1;
            wr_tmr_r <= WR_CYCLES - 32'h00000001;
         end
      end else begin
         if (wr_tmr_r != 32'h00000000) begin
            wr_tmr_r <= wr_tmr_r - 32'h00000001;
         end else if (!fifo_out_valid) begin
            busy_r <= 1'b0;
         end
      end
   end

   assign sda_o = sda_o_r;
   assign sda_oe = sda_oe_r;
   assign wr_busy = busy_r;

endmodule // tws_slave

`default_nettype wire

//--- shared/tws_defs.vh
// Constants for the two-wire serial memory slave front end
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// Clock and write cycle timing
`define TWS_CLK_PERIOD_NS 20
`define TWS_T_WR_NS 10000000

// Array and page geometry
`define TWS_ADDR_W 7
`define TWS_DATA_W 8
`define TWS_MEM_WORDS 128
`define TWS_PAGE_BITS 2
`define TWS_RW_BIT 0
`define TWS_DIR_READ 1'b1

// Bit count of one byte on the wire
`define TWS_BYTE_BITS 4'h8
`define TWS_CNT_ZERO 4'h0
`define TWS_CNT_ONE 4'h1

// Write data buffer
`define TWS_FIFO_DEPTH 32
`define TWS_FIFO_AW 5

// Kind of byte being received
`define TWS_KIND_CTRL 2'h0
`define TWS_KIND_WADDR 2'h1
`define TWS_KIND_DATA 2'h2

`endif

//--- verilog/tws_sync.v
// Two flip-flop synchroniser, one per input bit
`default_nettype none

module tws_sync #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Asynchronous inputs and synchronised copies
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_r;
         reg sync_r;
         // Idle level of the open-drain bus is high
         always @(posedge clk) begin
            if (srst) begin
               meta_r <= 1'b1;
               sync_r <= 1'b1;
            end else begin
               meta_r <= async_i[i];
               sync_r <= meta_r;
            end
         end
         assign sync_o[i] = sync_r;
      end
   endgenerate

endmodule // tws_sync

`default_nettype wire

//--- verilog/tws_fifo.v
// Synchronous FIFO with valid/ready on both sides
`default_nettype none

module tws_fifo #(
   parameter WIDTH = 15,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire clk,
   input wire srst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW:0] wptr_r;
   reg [AW:0] rptr_r;
   wire empty;
   wire full;
   wire push;
   wire pop;

   assign empty = (wptr_r == rptr_r);
   assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rptr_r[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always @(posedge clk) begin
      if (push) begin
         mem_r[wptr_r[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         wptr_r <= {(AW+1){1'b0}};
         rptr_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wptr_r <= wptr_r + {{AW{1'b0}}, 1'b1};
         end
         if (pop) begin
            rptr_r <= rptr_r + {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule // tws_fifo

`default_nettype wire

//--- verification/tws_slave_checker.sv
// Port-level assertions for the two-wire memory slave
`default_nettype none
module tws_slave_checker #(
   parameter int WR_CYCLES = 300
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus and status
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic wr_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic [31:0] busy_cnt_r;
   logic [31:0] busy_cnt_nxt;
   assign busy_cnt_nxt = wr_busy ? busy_cnt_r + 32'h1 : 32'h0;
   always @(posedge clk) begin
      if (srst) begin
         busy_cnt_r <= 32'h0;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   sequence s_scl_up;
      ##[1:12] $rose(scl_i);
   endsequence
   sequence s_quiet;
      !sda_oe [*8];
   endsequence
   chk_drive_is_low: assert property (sda_o == 1'b0)
      else $error("data pin driven high");
   chk_busy_no_ack: assert property (wr_busy |-> !sda_oe)
      else $error("data line pulled while busy");
   chk_oe_moves_low: assert property (!$stable(sda_oe) |-> !scl_i)
      else $error("data drive changed while clock high");
   chk_oe_held_pulse: assert property ($rose(sda_oe) |-> sda_oe throughout s_scl_up)
      else $error("drive not held into clock high");
   chk_stop_quiet: assert property (scl_i && $rose(sda_i) |-> s_quiet)
      else $error("drive after stop");
   chk_start_quiet: assert property (scl_i && $fell(sda_i) |-> s_quiet)
      else $error("drive during first bits after start");
   chk_busy_on_stop: assert property ($rose(wr_busy) |-> scl_i && sda_i && !$past(sda_i, 6))
      else $error("busy not started by stop");
   chk_busy_length: assert property ($fell(wr_busy) |->
         busy_cnt_r >= WR_CYCLES && busy_cnt_r <= WR_CYCLES + 33)
      else $error("programming time wrong");
endmodule // tws_slave_checker
`default_nettype wire

//--- verification/tws_bus_master.sv
// Behavioural bus master: clock, conditions and bytes
`default_nettype none
module tws_bus_master #(
   parameter int PH = 4
) (
   // Clock
   input wire logic clk,
   // Bus lines; sda_rel high lets the pull-up win
   output logic scl,
   output logic sda_rel,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic tk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start_c();
      if (!scl) begin
         tk(3);
         sda_rel = 1'b1;
         tk(PH - 3);
         scl = 1'b1;
      end
      tk(PH);
      sda_rel = 1'b0;
      tk(PH);
      scl = 1'b0;
   endtask
   task automatic stop_c();
      tk(3);
      sda_rel = 1'b0;
      tk(PH - 3);
      scl = 1'b1;
      tk(PH);
      sda_rel = 1'b1;
      tk(PH);
   endtask
   // Data moves 3 clocks into the low phase so the slave sees it settled
   task automatic bit_c(input logic b, output logic s);
      tk(3);
      sda_rel = b;
      tk(PH - 3);
      scl = 1'b1;
      tk(PH / 2);
      s = sda;
      tk(PH / 2);
      scl = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(d[i], s);
      end
      bit_c(1'b1, s);
      ack = !s;
   endtask
   task automatic recv(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, s);
         d[i] = s;
      end
      bit_c(!ack, s);
   endtask
endmodule // tws_bus_master
`default_nettype wire

//--- verification/test_tws_slave.sv
// Self-checking bench for the two-wire memory slave
`default_nettype none
module test_tws_slave;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WR_CYC = 300;
   logic clk;
   logic srst;
   logic scl;
   logic m_sda;
   logic sda_o;
   logic sda_oe;
   logic wr_busy;
   logic sda_w;
   logic a;
   logic [7:0] d;
   int errors;
   int samples_checked;
   assign sda_w = (sda_oe ? sda_o : 1'b1) & m_sda;
   tws_slave #(.WR_CYCLES(WR_CYC)) u_tws_slave (.clk(clk), .srst(srst), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .wr_busy(wr_busy));
   tws_bus_master u_tws_bus_master (.clk(clk), .scl(scl), .sda_rel(m_sda), .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] ad, input logic [7:0] q[$]);
      u_tws_bus_master.start_c();
      u_tws_bus_master.send({ad, 1'b0}, a);
      check(a, 1'b1);
      u_tws_bus_master.send({1'b0, ad}, a);
      check(a, 1'b1);
      foreach (q[i]) begin
         u_tws_bus_master.send(q[i], a);
         check(a, 1'b1);
      end
      u_tws_bus_master.stop_c();
      check(wr_busy, 1'b1);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (wr_busy !== 1'b0 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      check(n < 1000, 1'b1);
   endtask
   task automatic poll(output logic ack);
      u_tws_bus_master.start_c();
      u_tws_bus_master.send(8'h00, ack);
      u_tws_bus_master.stop_c();
   endtask
   task automatic rd(input logic [6:0] ad, input logic [7:0] exp[$]);
      u_tws_bus_master.start_c();
      u_tws_bus_master.send({ad, 1'b1}, a);
      check(a, 1'b1);
      foreach (exp[i]) begin
         u_tws_bus_master.recv(i < exp.size() - 1, d);
         check(d, exp[i]);
      end
      u_tws_bus_master.stop_c();
   endtask
   task automatic t_byte_write();
      logic p;
      wr(7'h10, '{8'h5A});
      poll(p);
      check(p, 1'b0);
      wait_done();
      poll(p);
      check(p, 1'b1);
      rd(7'h10, '{8'h5A});
   endtask
   // Further clocks after a refused byte must find the line released
   task automatic t_nack_idle();
      u_tws_bus_master.start_c();
      u_tws_bus_master.send({7'h10, 1'b1}, a);
      u_tws_bus_master.recv(1'b0, d);
      check(d, 8'h5A);
      u_tws_bus_master.recv(1'b0, d);
      check(d, 8'hFF);
      u_tws_bus_master.stop_c();
   endtask
   task automatic t_page_write();
      wr(7'h22, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5});
      wait_done();
      rd(7'h20, '{8'hA2, 8'hA3, 8'hA4, 8'hA5});
   endtask
   task automatic t_wrap_read();
      wr(7'h7F, '{8'hC3});
      wait_done();
      wr(7'h00, '{8'h3C});
      wait_done();
      rd(7'h7F, '{8'hC3, 8'h3C});
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      errors = 0;
      samples_checked = 0;
      srst = 1'b1;
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      t_byte_write();
      t_nack_idle();
      t_page_write();
      t_wrap_read();
      tally_and_finish();
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
endmodule // test_tws_slave
bind tws_slave tws_slave_checker #(.WR_CYCLES(WR_CYCLES)) u_tws_slave_checker (.clk(clk),
   .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .wr_busy(wr_busy));
`default_nettype wire
